// ### dv/rvc_regs_bench.sv
// Self-checking bench for the regulator voltage code register bank.
// Assumes the rvc_pkg package and the rvc_regs module with default
// parameters; the bench drives every port itself at the rising clock edge.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module rvc_regs_bench
  import rvc_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals.
  logic       clk_sys_i       = 1'b0;
  logic       arst_n_i        = 1'b0;
  logic       ce_i            = 1'b1;
  rvc_req_s   req             = '0;
  logic       sleep_state_n_i = 1'b1;
  logic [7:0] rdata_o;
  logic       rd_valid_o;
  logic [6:0] step_down_b_code_o;
  logic [6:0] step_down_c_code_o;
  logic [3:0] linear_reg_code_o;
  logic [2:0] pgood_hold_o;
  int         mismatches = 0;
  int         num_checks = 0;

  // The 200 MHz system clock.
  always #2.5 clk_sys_i = ~clk_sys_i;

  rvc_regs dut (
    .clk_sys_i          (clk_sys_i),
    .arst_n_i           (arst_n_i),
    .ce_i               (ce_i),
    .req_i              (req),
    .rdata_o            (rdata_o),
    .rd_valid_o         (rd_valid_o),
    .sleep_state_n_i    (sleep_state_n_i),
    .step_down_b_code_o (step_down_b_code_o),
    .step_down_c_code_o (step_down_c_code_o),
    .linear_reg_code_o  (linear_reg_code_o),
    .pgood_hold_o       (pgood_hold_o)
  );

  // ==========================================================================
  // Bus helpers.
  // Lets n edges pass, then steps past their updates.
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // One write cycle; the request is taken at the second edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req <= '0;
  endtask

  // One read cycle; the answer is checked in its single valid cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    req <= '0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid_o)
    `CHK("rdata", e, rdata_o)
  endtask

  // ==========================================================================
  // Scenarios.
  // Reset values in the registers and on the code outputs.
  task automatic t_reset;
    rd(RVC_OFS_STEP_B, 8'h4b);
    rd(RVC_OFS_STEP_C, RVC_RST_STEP_C);
    rd(RVC_OFS_LINEAR, 8'haa);
    `CHK("code_b", 7'h4b, step_down_b_code_o)
    `CHK("code_c", RVC_RST_STEP_C[6:0], step_down_c_code_o)
    `CHK("code_lin", 4'ha, linear_reg_code_o)
    `CHK("pgood", 3'h0, pgood_hold_o)
  endtask

  // Reserved top bits store but stay off the codes; zero codes hold pgood.
  task automatic t_step;
    wr(RVC_OFS_STEP_B, 8'h80);
    idle(2);
    `CHK("code_b", 7'h00, step_down_b_code_o)
    `CHK("pgood", 3'h1, pgood_hold_o)
    rd(RVC_OFS_STEP_B, 8'h80);
    wr(RVC_OFS_STEP_B, 8'h7f);
    wr(RVC_OFS_STEP_C, 8'h00);
    idle(2);
    `CHK("code_b", 7'h7f, step_down_b_code_o)
    `CHK("pgood", 3'h2, pgood_hold_o)
    rd(RVC_OFS_STEP_C, 8'h00);
    wr(RVC_OFS_STEP_C, 8'hff);
    idle(2);
    `CHK("code_c", 7'h7f, step_down_c_code_o)
    rd(RVC_OFS_STEP_C, 8'hff);
  endtask

  // Split linear codes follow the synchronised sleep pin.
  task automatic t_linear;
    wr(RVC_OFS_LINEAR, 8'h05);
    idle(2);
    `CHK("code_lin", 4'h5, linear_reg_code_o)
    @(posedge clk_sys_i);
    sleep_state_n_i <= 1'b0;
    idle(2);
    `CHK("code_lin", 4'h5, linear_reg_code_o)
    idle(1);
    `CHK("code_lin", 4'h0, linear_reg_code_o)
    `CHK("pgood", 3'h4, pgood_hold_o)
    wr(RVC_OFS_LINEAR, 8'h9c);
    idle(2);
    `CHK("code_lin", 4'h9, linear_reg_code_o)
    @(posedge clk_sys_i);
    sleep_state_n_i <= 1'b1;
    idle(3);
    `CHK("code_lin", 4'hc, linear_reg_code_o)
    rd(RVC_OFS_LINEAR, 8'h9c);
    wr(RVC_OFS_LINEAR, 8'h77);
    idle(2);
    `CHK("code_lin", 4'h7, linear_reg_code_o)
    @(posedge clk_sys_i);
    sleep_state_n_i <= 1'b0;
    idle(3);
    `CHK("code_lin", 4'h7, linear_reg_code_o)
    @(posedge clk_sys_i);
    sleep_state_n_i <= 1'b1;
    idle(3);
  endtask

  // Unmapped offsets and a disabled clock enable leave the bank untouched.
  task automatic t_misc;
    wr(8'h97, 8'h11);
    rd(8'h97, RVC_RDATA_UNMAP);
    rd(8'h9b, RVC_RDATA_UNMAP);
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(RVC_OFS_STEP_B, 8'h22);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    rd(RVC_OFS_STEP_B, 8'h7f);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    idle(2);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(RVC_OFS_LINEAR, 8'haa);
    rd(RVC_OFS_STEP_B, 8'h4b);
  endtask

  // Write and read in one cycle, then a read right behind the write.
  task automatic t_back;
    @(posedge clk_sys_i);
    req <= '{wr: 1'b1, rd: 1'b1, addr: RVC_OFS_STEP_B, wdata: 8'h85};
    @(posedge clk_sys_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: RVC_OFS_STEP_B, wdata: 8'h00};
    #1;
    `CHK("rdata_old", 8'h4b, rdata_o)
    @(posedge clk_sys_i);
    req <= '0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid_o)
    `CHK("rdata_new", 8'h85, rdata_o)
    idle(1);
    `CHK("rd_valid_end", 1'b0, rd_valid_o)
    `CHK("rdata_hold", 8'h85, rdata_o)
    `CHK("code_b", 7'h05, step_down_b_code_o)
    `CHK("pgood", 3'h0, pgood_hold_o)
  endtask

  // ==========================================================================
  // Verdict and end of run.
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence: three cycles of reset, then every scenario.
  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_step();
    t_linear();
    t_misc();
    t_back();
    final_report();
  end

  // Watchdog well beyond the fewer than one hundred cycles the scenarios need.
  initial begin
    #10000;
    mismatches++;
    final_report();
  end

endmodule // rvc_regs_bench

`default_nettype wire

// ### verilog/rvc_pkg.sv
// Constants and carrier types for the regulator voltage code register bank.
// Assumes a serial management front end that hands over decoded byte
// accesses, one request per cycle, on the system clock.
`default_nettype none

package rvc_pkg;

  // ==========================================================================
  // Register offsets and geometry.
  localparam logic [7:0] RVC_OFS_STEP_B  = 8'h96;
  localparam logic [7:0] RVC_OFS_STEP_C  = 8'h98;
  localparam logic [7:0] RVC_OFS_LINEAR  = 8'h9a;
  localparam int         RVC_NREG        = 3;
  localparam logic [1:0] RVC_IDX_STEP_B  = 2'h0;
  localparam logic [1:0] RVC_IDX_STEP_C  = 2'h1;
  localparam logic [1:0] RVC_IDX_LINEAR  = 2'h2;
  localparam logic [1:0] RVC_IDX_NONE    = 2'h3;

  // ==========================================================================
  // Field positions.
  localparam int         RVC_STEP_CODE_MSB = 6;
  localparam int         RVC_LIN_SLP_MSB   = 7;
  localparam int         RVC_LIN_SLP_LSB   = 4;
  localparam int         RVC_LIN_NRM_MSB   = 3;

  // ==========================================================================
  // Reset values, the second and third being variant defaults; then the unmapped read value.
  localparam logic [7:0] RVC_RST_STEP_B   = 8'h4b;
  localparam logic [7:0] RVC_RST_STEP_C   = 8'h3d;
  localparam logic [7:0] RVC_RST_LINEAR   = 8'haa;
  localparam logic [7:0] RVC_RDATA_UNMAP  = 8'h00;

  // ==========================================================================
  // Access request from the serial management front end.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rvc_req_s;

  // Maps a byte offset onto a register index, or none.
  function automatic logic [1:0] rvc_decode(input logic [7:0] addr);
    case (addr)
      RVC_OFS_STEP_B: rvc_decode = RVC_IDX_STEP_B;
      RVC_OFS_STEP_C: rvc_decode = RVC_IDX_STEP_C;
      RVC_OFS_LINEAR: rvc_decode = RVC_IDX_LINEAR;
      default:        rvc_decode = RVC_IDX_NONE;
    endcase
  endfunction

endpackage : rvc_pkg

`default_nettype wire

// ### verilog/rvc_reg_cell.sv
// One byte-wide read/write register with a constant reset value.
// Assumes the write strobe is already decoded and synchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none

module rvc_reg_cell #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // Clock, reset and enable.
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  // Write port.
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Stored value.
  output logic      [7:0] q_o
);

  logic [7:0] q_q;
  logic [7:0] q_d;

  // ==========================================================================
  // Every bit, reserved ones included, takes the written byte.
  always_comb begin
    q_d = q_q;
    if (ce_i && wr_i) begin
      q_d = wdata_i;
    end
  end

  // Holds the register; reset loads the fixed default.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_q <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign q_o = q_q;

endmodule // rvc_reg_cell

`default_nettype wire

// ### verilog/rvc_regs.sv
// Regulator voltage code register bank: two step-down codes and a split
// sleep/normal linear regulator code, with registered code outputs.
// Assumes decoded byte accesses from the serial front end on clk_sys_i and
// an asynchronous sleep-state pin that is synchronised here.
//
// How it works
// - Step-down B code register at 0x96, code in bits 6..0, resets to 0x4b.
// - A zero code is legal and holds the power-good indication high.
// - Step-down C code register at 0x98, seven-bit code, variant reset value.
// - Linear register at 0x9a: sleep code bits 7..4, normal code bits 3..0.
// - Linear output uses the sleep code while sleep_state_n is low.
// - Both linear codes reset to a variant value, 1010 or 0000.
// - Every bit of all three registers is readable and writable.
`timescale 1ns/100ps
`default_nettype none

module rvc_regs
  import rvc_pkg::*;
#(
  parameter logic [7:0] RST_STEP_C = RVC_RST_STEP_C,
  parameter logic [7:0] RST_LINEAR = RVC_RST_LINEAR
) (
  // Clock, reset and enable.
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  // Register access from the serial front end.
  input  wire rvc_req_s   req_i,
  output logic      [7:0] rdata_o,
  output logic            rd_valid_o,
  // Sleep-state pin, active low.
  input  wire logic       sleep_state_n_i,
  // Regulator codes and power-good holds.
  output logic      [6:0] step_down_b_code_o,
  output logic      [6:0] step_down_c_code_o,
  output logic      [3:0] linear_reg_code_o,
  output logic      [2:0] pgood_hold_o
);

  localparam logic [7:0] RST_TABLE [RVC_NREG] =
    '{RVC_RST_STEP_B, RST_STEP_C, RST_LINEAR};

  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [7:0] reg_q [RVC_NREG];

  // ==========================================================================
  // Register storage.
  assign wr_idx = rvc_decode(req_i.addr);
  assign rd_idx = wr_idx;

  // One cell per register, each with its own reset value.
  generate
    for (genvar i = 0; i < RVC_NREG; i++) begin : g_cell
      rvc_reg_cell #(
        .RST_VAL   (RST_TABLE[i])
      ) u_cell (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .wr_i      (req_i.wr && (wr_idx == 2'(i))),
        .wdata_i   (req_i.wdata),
        .q_o       (reg_q[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Read path.
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rd_valid_q;
  logic       rd_valid_d;

  // Returns the whole stored byte; unmapped offsets read as zero.
  always_comb begin
    rdata_d    = rdata_q;
    rd_valid_d = rd_valid_q;
    if (ce_i) begin
      rd_valid_d = req_i.rd;
      if (req_i.rd) begin
        case (rd_idx)
          RVC_IDX_STEP_B: rdata_d = reg_q[0];
          RVC_IDX_STEP_C: rdata_d = reg_q[1];
          RVC_IDX_LINEAR: rdata_d = reg_q[2];
          default:        rdata_d = RVC_RDATA_UNMAP;
        endcase
      end
    end
  end

  // Registers the read answer.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rdata_o    = rdata_q;
  assign rd_valid_o = rd_valid_q;

  // ==========================================================================
  // Sleep-state synchroniser and code outputs.
  logic       slp_meta_q;
  logic       slp_sync_q;
  logic [6:0] code_b_q;
  logic [6:0] code_c_q;
  logic [3:0] code_l_q;
  logic [2:0] pg_q;
  logic       slp_meta_d;
  logic       slp_sync_d;
  logic [6:0] code_b_d;
  logic [6:0] code_c_d;
  logic [3:0] code_l_d;
  logic [2:0] pg_d;

  // Picks the active linear code and flags zero codes for power-good.
  always_comb begin
    slp_meta_d = slp_meta_q;
    slp_sync_d = slp_sync_q;
    code_b_d   = code_b_q;
    code_c_d   = code_c_q;
    code_l_d   = code_l_q;
    pg_d       = pg_q;
    if (ce_i) begin
      slp_meta_d = sleep_state_n_i;
      slp_sync_d = slp_meta_q;
      // Bit 7 is left out of both step-down codes.
      code_b_d   = reg_q[0][RVC_STEP_CODE_MSB:0];
      code_c_d   = reg_q[1][RVC_STEP_CODE_MSB:0];
      if (!slp_sync_q) begin
        code_l_d = reg_q[2][RVC_LIN_SLP_MSB:RVC_LIN_SLP_LSB];
      end else begin
        code_l_d = reg_q[2][RVC_LIN_NRM_MSB:0];
      end
      // A zero code is passed through unchanged and holds power-good.
      pg_d[0] = (code_b_d == 7'h00);
      pg_d[1] = (code_c_d == 7'h00);
      pg_d[2] = (code_l_d == 4'h0);
    end
  end

  // Registers the synchroniser and all regulator-facing outputs.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slp_meta_q <= 1'b1;
      slp_sync_q <= 1'b1;
      code_b_q   <= RVC_RST_STEP_B[6:0];
      code_c_q   <= RST_STEP_C[6:0];
      code_l_q   <= RST_LINEAR[3:0];
      // A zero reset code must hold power-good from the very first cycle.
      pg_q       <= {(RST_LINEAR[3:0] == 4'h0),
                     (RST_STEP_C[6:0] == 7'h00),
                     (RVC_RST_STEP_B[6:0] == 7'h00)};
    end else begin
      slp_meta_q <= slp_meta_d;
      slp_sync_q <= slp_sync_d;
      code_b_q   <= code_b_d;
      code_c_q   <= code_c_d;
      code_l_q   <= code_l_d;
      pg_q       <= pg_d;
    end
  end

  assign step_down_b_code_o = code_b_q;
  assign step_down_c_code_o = code_c_q;
  assign linear_reg_code_o  = code_l_q;
  assign pgood_hold_o       = pg_q;

  // ==========================================================================
  // Assertions.
  logic wr_b;
  logic wr_c;
  logic wr_l;
  assign wr_b = req_i.wr && (wr_idx == RVC_IDX_STEP_B);
  assign wr_c = req_i.wr && (wr_idx == RVC_IDX_STEP_C);
  assign wr_l = req_i.wr && (wr_idx == RVC_IDX_LINEAR);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i || !ce_i);

  sequence seq_sleep_low;
    (!sleep_state_n_i && !wr_l) [*4];
  endsequence

  sequence seq_sleep_high;
    (sleep_state_n_i && !wr_l) [*4];
  endsequence

  chk_step_b_store: assert property (
    wr_b |=> ##1 step_down_b_code_o == $past(req_i.wdata[6:0], 2))
    else $error("Step-down B code did not follow the write.");

  chk_zero_pgood: assert property (
    (step_down_b_code_o == 7'h00) |-> pgood_hold_o[0])
    else $error("Zero step-down B code without power-good hold.");

  chk_step_c_store: assert property (
    wr_c |=> ##1 step_down_c_code_o == $past(req_i.wdata[6:0], 2))
    else $error("Step-down C code did not follow the write.");

  chk_lin_sleep_sel: assert property (
    seq_sleep_low |-> linear_reg_code_o == reg_q[2][7:4])
    else $error("Linear output not on sleep code while asleep.");

  chk_lin_normal_sel: assert property (
    seq_sleep_high |-> linear_reg_code_o == reg_q[2][3:0])
    else $error("Linear output not on normal code while awake.");

  chk_lin_store: assert property (
    wr_l |=> reg_q[2] == $past(req_i.wdata))
    else $error("Linear code register did not store both fields.");

  chk_read_back: assert property (
    (req_i.rd && rd_idx == RVC_IDX_STEP_C) |=>
      rd_valid_o && rdata_o == $past(reg_q[1]))
    else $error("Read of step-down C register returned wrong byte.");

  chk_resv_keep: assert property (
    wr_b ##1 (req_i.rd && rd_idx == RVC_IDX_STEP_B && !wr_b) |=>
      rdata_o[7] == $past(req_i.wdata[7], 2))
    else $error("Reserved bit was not stored and returned.");

  chk_unmapped_read: assert property (
    (req_i.rd && rd_idx == RVC_IDX_NONE) |=> rdata_o == RVC_RDATA_UNMAP)
    else $error("Unmapped read did not return zero.");

  chk_pgood_all: assert property (
    pgood_hold_o == {(linear_reg_code_o == 4'h0),
                     (step_down_c_code_o == 7'h00),
                     (step_down_b_code_o == 7'h00)})
    else $error("Power-good holds do not match the zero codes.");

  chk_valid_pulse: assert property (
    !req_i.rd |=> !rd_valid_o)
    else $error("Read valid rose without a taken read.");

endmodule // rvc_regs

`default_nettype wire
